// [core/exc_ctl_defines.svh]
// Constants for the per-thread exception status and control word.
// Assumes inclusion by bare name from files under core/.
`ifndef EXC_CTL_DEFINES_SVH
`define EXC_CTL_DEFINES_SVH

// ****************************************
// Field positions of the control word
// ****************************************
`define BIT_BKPT_STAT   31
`define BIT_HALT_STAT   30
`define BIT_SWEXC       29
`define BIT_ILLOP_STAT  28
`define BIT_LOVF_STAT   27
`define BIT_LUNF_STAT   26
`define BIT_COVF_STAT   25
`define BIT_CUNF_STAT   24
`define BIT_BKPT_EN     15
`define BIT_HALT_EN     14
`define BIT_SWEXC_EN    13
`define BIT_ILLOP_EN    12
`define BIT_MSTK_EN     11

// ****************************************
// Reset values and pointer widths
// ****************************************
`define STAT_RESET      8'h00
`define EN_RESET        5'h00
`define IP_LSB          4
`define IP_W            32

`endif

// [core/exc_ctl_pkg.sv]
// Types shared by the exception control block and its pointer unit.
// Assumes the defines header is compiled alongside.
package exc_ctl_pkg;

    // Cause of an exception entry, binary coded
    typedef enum logic [2:0] {
        CAUSE_NONE  = 3'h0,
        CAUSE_BKPT  = 3'h1,
        CAUSE_HALT  = 3'h2,
        CAUSE_SWEXC = 3'h3,
        CAUSE_ILLOP = 3'h4,
        CAUSE_MSTK  = 3'h5
    } cause_t;

    // Thread mode, binary coded
    typedef enum logic [0:0] {
        MODE_APP = 1'h0,
        MODE_SYS = 1'h1
    } mode_t;

endpackage : exc_ctl_pkg

// [core/exc_ptr_unit.sv]
// Saved application pointer and redirect target computation.
// Assumes entry and return are never requested in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "exc_ctl_defines.svh"
module exc_ptr_unit
    import exc_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_sys,
    input  wire logic     nrst,
    input  wire logic     ce,
    // Requests from the control word
    exc_redirect_if.ptr   rq
);
    logic [31:0] saved_ff;
    logic [31:0] one_step;

    // One instruction step in pointer units
    assign one_step = 32'h1 << `IP_LSB;

    // Faulting or following instruction per cause
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            saved_ff <= 32'h0;
        end else if (ce && rq.enter) begin
            if (rq.cause == CAUSE_SWEXC || rq.cause == CAUSE_MSTK) begin
                saved_ff <= rq.cur_ip + one_step;
            end else begin
                saved_ff <= rq.cur_ip;
            end
        end
    end

    assign rq.saved_ip = saved_ff;
endmodule : exc_ptr_unit
`default_nettype wire

// [core/exc_redirect_if.sv]
// Interface carrying entry/return requests to the pointer unit.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface exc_redirect_if;
    import exc_ctl_pkg::*;
    logic        enter;
    logic        leave;
    cause_t      cause;
    logic [31:0] cur_ip;
    logic [31:0] saved_ip;
    modport ctl (output enter, leave, cause, cur_ip, input saved_ip);
    modport ptr (input enter, leave, cause, cur_ip, output saved_ip);
endinterface : exc_redirect_if
`default_nettype wire

// [core/thread_exception_status_control.sv]
// Per-thread exception status and control word of an execution unit.
// Assumes the pipeline reports causes as one-cycle pulses with the
// current instruction pointer, and obeys redirect requests at once.
`timescale 1ns/1ps
`default_nettype none
`include "exc_ctl_defines.svh"

module thread_exception_status_control
    import exc_ctl_pkg::*;
#(
    parameter bit HAS_MSTK_EN = 1'b1
)(
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Thread dispatch
    input  wire logic        dispatch,
    input  wire logic [4:0]  dispatch_en,
    // Control word operand access
    input  wire logic        word_wr,
    input  wire logic [31:0] word_wdata,
    output logic      [31:0] word_rdata,
    // Master exception state and suppress from thread control word
    input  wire logic        master_wr,
    input  wire logic        master_wdata,
    input  wire logic        suppress_wr,
    input  wire logic        suppress_wdata,
    output logic             master_state,
    output logic             suppress,
    // Pipeline event reports
    input  wire logic        inst_retire,
    input  wire logic        inst_bkpt,
    input  wire logic        inst_compressed,
    input  wire logic [31:0] cur_ip,
    input  wire logic        illop_evt,
    input  wire logic        lovf_evt,
    input  wire logic        lunf_evt,
    input  wire logic        covf_evt,
    input  wire logic        cunf_evt,
    // Halt broadcast pin
    input  wire logic        ext_halt_pin,
    // Redirect to pipeline
    output logic             redirect,
    output logic      [31:0] redirect_ip,
    output logic             hold_ip
);
    // ****************************************
    // Storage
    // ****************************************
    logic [7:0]  stat_ff;
    logic [4:0]  en_ff;
    mode_t       mode_ff;
    logic        supp_ff;
    logic        step_ff;
    logic        redirect_ff;
    logic [31:0] redirect_ip_ff;
    logic        hold_ff;
    logic [2:0]  halt_sync_ff;
    logic        halt_seen_ff;
    logic        halt_evt;
    logic        take;
    cause_t      nxt_cause;
    logic        leave;
    logic [31:0] rdata;
    logic [7:0]  nxt_stat;

    // All checks below share this clock and reset
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    exc_redirect_if rq ();

    exc_ptr_unit u_ptr (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .rq      (rq.ptr)
    );

    // ****************************************
    // Halt pin synchroniser
    // ****************************************
    // Third stage only compared with second, never gated from the first
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            halt_sync_ff <= 3'h0;
            halt_seen_ff <= 1'b0;
        end else if (ce) begin
            halt_sync_ff <= {halt_sync_ff[1:0], ext_halt_pin};
            if (halt_sync_ff[2] == halt_sync_ff[1]) begin
                halt_seen_ff <= halt_sync_ff[2];
            end
        end
    end
    assign halt_evt = (halt_sync_ff[2] == halt_sync_ff[1])
                      && halt_sync_ff[2] && !halt_seen_ff;

    // ****************************************
    // Cause selection
    // ****************************************
    // Live events feed this, and of the leftover status bits only the halt bit stat_ff[6]
    always_comb begin
        nxt_cause = CAUSE_NONE;
        if (mode_ff == MODE_APP) begin
            if (illop_evt && en_ff[1]) begin
                nxt_cause = CAUSE_ILLOP;
            end else if (inst_bkpt && en_ff[4] && !supp_ff) begin
                nxt_cause = CAUSE_BKPT;
            end else if (step_ff && inst_retire) begin
                nxt_cause = CAUSE_BKPT;
            end else if ((lovf_evt | lunf_evt | covf_evt | cunf_evt)
                         && en_ff[0]) begin
                nxt_cause = CAUSE_MSTK;
            end else if (word_wr && word_wdata[`BIT_SWEXC]
                         && en_ff[2]) begin
                nxt_cause = CAUSE_SWEXC;
            end else if ((halt_evt || stat_ff[6]) && en_ff[3]) begin
                nxt_cause = CAUSE_HALT;
            end
        end
    end
    assign take  = ce && (nxt_cause != CAUSE_NONE);
    assign leave = ce && master_wr && !master_wdata
                   && (mode_ff == MODE_SYS);

    assign rq.enter  = take;
    assign rq.leave  = leave;
    assign rq.cause  = nxt_cause;
    assign rq.cur_ip = cur_ip;

    // ****************************************
    // Status flags
    // ****************************************
    // Hardware sets win over a same-cycle software clear
    always_comb begin
        nxt_stat = stat_ff;
        if (word_wr) begin
            nxt_stat[7] = word_wdata[`BIT_BKPT_STAT];
            nxt_stat[6] = word_wdata[`BIT_HALT_STAT];
            if (mode_ff == MODE_SYS) begin
                nxt_stat[5] = word_wdata[`BIT_SWEXC];
                nxt_stat[4:0] = word_wdata[`BIT_ILLOP_STAT:`BIT_CUNF_STAT];
            end else if (word_wdata[`BIT_SWEXC]) begin
                nxt_stat[5] = 1'b1;
            end
        end
        if (halt_evt) nxt_stat[6] = 1'b1;
        if (take && nxt_cause == CAUSE_BKPT) nxt_stat[7] = 1'b1;
        if (take && nxt_cause == CAUSE_SWEXC) nxt_stat[5] = 1'b1;
        if (illop_evt) nxt_stat[4] = 1'b1;
        if (lovf_evt) nxt_stat[3] = 1'b1;
        if (lunf_evt) nxt_stat[2] = 1'b1;
        if (covf_evt) nxt_stat[1] = 1'b1;
        if (cunf_evt) nxt_stat[0] = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            stat_ff <= `STAT_RESET;
        end else if (ce) begin
            stat_ff <= nxt_stat;
        end
    end

    // ****************************************
    // Enable bits
    // ****************************************
    // No fixed value beyond reset; launch loads them
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            en_ff <= `EN_RESET;
        end else if (ce) begin
            if (dispatch) begin
                en_ff <= dispatch_en & {4'hF, HAS_MSTK_EN};
            end else if (word_wr) begin
                en_ff <= word_wdata[`BIT_BKPT_EN:`BIT_MSTK_EN]
                         & {4'hF, HAS_MSTK_EN};
            end
        end
    end

    // ****************************************
    // Mode, suppress and single step
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            mode_ff <= MODE_APP;
            supp_ff <= 1'b0;
            step_ff <= 1'b0;
        end else if (ce) begin
            if (take) begin
                mode_ff <= MODE_SYS;
                step_ff <= 1'b0;
            end else if (leave) begin
                mode_ff <= MODE_APP;
                // Status left set with suppress: one step then back
                step_ff <= stat_ff[7] && supp_ff;
            end else if (step_ff && inst_retire) begin
                step_ff <= 1'b0;
            end
            if (suppress_wr) begin
                supp_ff <= suppress_wdata;
            end else if (mode_ff == MODE_APP && supp_ff
                         && inst_bkpt && en_ff[4]) begin
                supp_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Redirect outputs
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            redirect_ff    <= 1'b0;
            redirect_ip_ff <= 32'h0;
            hold_ff        <= 1'b0;
        end else if (ce) begin
            redirect_ff <= take || leave;
            if (leave) begin
                redirect_ip_ff <= rq.saved_ip;
            end
            // Stepping a compressed op leaves the pointer where it was
            hold_ff <= step_ff && inst_compressed;
        end
    end

    // Read view of the word
    always_comb begin
        rdata = 32'h0;
        rdata[`BIT_BKPT_STAT:`BIT_CUNF_STAT] = stat_ff;
        rdata[`BIT_BKPT_EN:`BIT_MSTK_EN]     = en_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            word_rdata <= 32'h0;
        end else if (ce) begin
            word_rdata <= rdata;
        end
    end

    assign master_state = mode_ff;
    assign suppress     = supp_ff;
    assign redirect     = redirect_ff;
    assign redirect_ip  = redirect_ip_ff;
    assign hold_ip      = hold_ff;

    // ****************************************
    // Checks
    // ****************************************
    // Entry shows exception state and redirect in the same cycle
    sequence seq_entered;
        mode_ff == MODE_SYS ##0 redirect_ff;
    endsequence
    // A return with status and suppress kept arms one step
    sequence seq_step_armed;
        mode_ff == MODE_APP ##0 step_ff;
    endsequence

    chk_entry_sets_mode: assert property (
        take |=> seq_entered)
        else $error("entry did not set exception state");
    chk_bkpt_status: assert property (
        take && nxt_cause == CAUSE_BKPT |=> stat_ff[7])
        else $error("breakpoint status not set");
    chk_no_nested: assert property (
        ce && mode_ff == MODE_SYS && !leave
        |=> mode_ff == MODE_SYS && !redirect_ff)
        else $error("exception taken in system routine");
    chk_halt_flag: assert property (
        ce && halt_evt |=> stat_ff[6])
        else $error("halt flag not set");
    chk_leave_ip: assert property (
        leave |=> redirect_ff && redirect_ip_ff == $past(rq.saved_ip))
        else $error("resume pointer wrong");
    chk_supp_clear: assert property (
        ce && !suppress_wr && mode_ff == MODE_APP && supp_ff && inst_bkpt
        && en_ff[4] |=> !supp_ff)
        else $error("suppress not cleared");
    chk_swexc_hold: assert property (
        take && nxt_cause == CAUSE_SWEXC |=> stat_ff[5])
        else $error("software exception bit dropped");
    chk_dispatch_en: assert property (
        ce && dispatch |=> en_ff == ($past(dispatch_en)
        & {4'hF, HAS_MSTK_EN}))
        else $error("enables not loaded at dispatch");
    chk_step_arm: assert property (
        leave && stat_ff[7] && supp_ff |=> seq_step_armed)
        else $error("single step not armed on return");
    chk_step_reenter: assert property (
        step_ff && inst_retire && ce && mode_ff == MODE_APP && !illop_evt
        |-> take)
        else $error("single step did not re-enter");
endmodule : thread_exception_status_control
`default_nettype wire

// [tb/pipe_model.sv]
// Pipeline stand-in: keeps the application instruction pointer.
// Assumes pulses from the bench and redirects from the control block.
`timescale 1ns/1ps
`default_nettype none
module pipe_model #(
    parameter logic [31:0] START_IP = 32'h0000_0100
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Pipeline activity and redirects
    input  wire logic        retire,
    input  wire logic        hold_ip,
    input  wire logic        redirect,
    input  wire logic        master_state,
    input  wire logic [31:0] redirect_ip,
    // Current instruction pointer
    output logic      [31:0] cur_ip
);
    // ****************************************
    // Pointer tracking
    // ****************************************
    // Resume wins over advance; a hold rewinds the step already taken
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cur_ip <= START_IP;
        end else if (redirect && !master_state) begin
            cur_ip <= redirect_ip;
        end else if (hold_ip) begin
            cur_ip <= cur_ip - 32'h0000_0010;
        end else if (retire) begin
            cur_ip <= cur_ip + 32'h0000_0010;
        end
    end
endmodule : pipe_model
`default_nettype wire

// [tb/test_thread_exception_status_control.sv]
// Self-checking bench for the exception status and control word.
// Assumes the pipeline model alongside; all stimulus on falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_thread_exception_status_control;
    import exc_ctl_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        dispatch = 1'b0;
    logic [4:0]  en = 5'h00;
    logic        word_wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        master_wr = 1'b0;
    logic        suppress_wr = 1'b0;
    logic        ext_halt = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [31:0] word_rdata, redirect_ip, cur_ip, ip_x;
    logic        master_state, suppress, redirect, hold_ip;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    // Event bits: retire, bkpt, compressed, illop, lovf, lunf, covf, cunf
    localparam logic [7:0] EV_RET = 8'h80;
    localparam logic [7:0] EV_BKPT = 8'h40;
    localparam logic [7:0] EV_CMP = 8'h20;

    thread_exception_status_control dut (
        .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .dispatch(dispatch), .dispatch_en(en),
        .word_wr(word_wr), .word_wdata(wdata), .word_rdata(word_rdata),
        .master_wr(master_wr), .master_wdata(1'b0),
        .suppress_wr(suppress_wr), .suppress_wdata(1'b1),
        .master_state(master_state), .suppress(suppress),
        .inst_retire(ev[7]), .inst_bkpt(ev[6]), .inst_compressed(ev[5]),
        .cur_ip(cur_ip), .illop_evt(ev[4]), .lovf_evt(ev[3]),
        .lunf_evt(ev[2]), .covf_evt(ev[1]), .cunf_evt(ev[0]),
        .ext_halt_pin(ext_halt), .redirect(redirect),
        .redirect_ip(redirect_ip), .hold_ip(hold_ip)
    );

    pipe_model pipe (
        .clk_sys(clk_sys), .nrst(nrst), .retire(ev[7]), .hold_ip(hold_ip),
        .redirect(redirect), .master_state(master_state),
        .redirect_ip(redirect_ip), .cur_ip(cur_ip)
    );

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    // Free-running system clock
    always #5 clk_sys = ~clk_sys;

    // Hang guard, far above the less than a hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick();
        @(negedge clk_sys);
    endtask : tick

    // Every strobe lasts one taking edge; callers enter on a falling edge
    task automatic pulse(input logic [7:0] e);
        ev = e;
        tick();
        ev = 8'h00;
    endtask : pulse

    task automatic wr_word(input logic [31:0] d);
        word_wr = 1'b1;
        wdata = d;
        tick();
        word_wr = 1'b0;
    endtask : wr_word

    // Optional suppress set, optional return to the application
    task automatic ctl(input bit sup, input bit lv);
        suppress_wr = sup;
        master_wr = lv;
        tick();
        suppress_wr = 1'b0;
        master_wr = 1'b0;
    endtask : ctl

    task automatic disp(input logic [4:0] e);
        dispatch = 1'b1;
        en = e;
        tick();
        dispatch = 1'b0;
        tick();
        chk(word_rdata[15:11], e);
    endtask : disp

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        tick();
        nrst = 1'b1;
        tick();
        chk(word_rdata, 32'h0000_0000);
        chk(master_state, 1'b0);
        disp(5'h1F);
        $display("reset and dispatch done");
        // Breakpoint entry; suppress lands two cycles before the return,
        // since the step decision looks at the suppress already held
        ip_x = cur_ip;
        pulse(EV_RET | EV_BKPT);
        chk({master_state, redirect}, 2'h3);
        tick();
        chk(word_rdata[31], 1'b1);
        ctl(1'b1, 1'b0);
        tick();
        ctl(1'b0, 1'b1);
        chk(redirect_ip, ip_x);
        pulse(EV_RET);
        chk(master_state, 1'b1);
        ctl(1'b1, 1'b1);
        pulse(EV_RET | EV_CMP);
        chk(hold_ip, 1'b1);
        wr_word(32'h0000_F800);
        tick();
        chk(word_rdata[31], 1'b0);
        ctl(1'b1, 1'b1);
        pulse(EV_RET | EV_BKPT);
        chk(master_state, 1'b0);
        tick();
        chk(suppress, 1'b0);
        $display("breakpoint tests done");
        // Halt broadcast through the pin synchroniser
        ext_halt = 1'b1;
        for (int k = 0; k < 10 && master_state !== 1'b1; k++) tick();
        ext_halt = 1'b0;
        chk(master_state, 1'b1);
        tick();
        chk(word_rdata[30], 1'b1);
        wr_word(32'h0000_F800);
        tick();
        chk(word_rdata[30], 1'b0);
        ctl(1'b0, 1'b1);
        $display("halt test done");
        // Software exception, with a breakpoint ignored inside the routine
        ip_x = cur_ip;
        wr_word(32'h2000_F800);
        chk(master_state, 1'b1);
        pulse(EV_RET | EV_BKPT);
        chk(redirect, 1'b0);
        chk(word_rdata[29], 1'b1);
        wr_word(32'h0000_F800);
        ctl(1'b0, 1'b1);
        chk(redirect_ip, ip_x + 32'h0000_0010);
        $display("software exception test done");
        // Illegal opcode and the four stack causes, flags left set;
        // an idle cycle keeps two strobes from meeting in one step
        for (int i = 0; i < 5; i++) begin
            ip_x = cur_ip;
            pulse(8'h10 >> i);
            chk(master_state, 1'b1);
            tick();
            chk(word_rdata[28 - i], 1'b1);
            ctl(1'b0, 1'b1);
            chk(redirect_ip, ip_x + (i == 0 ? 32'h0 : 32'h10));
            pulse(EV_RET);
            chk(master_state, 1'b0);
            tick();
        end
        $display("illegal opcode and stack tests done");
        // All causes disabled by a fresh dispatch
        disp(5'h00);
        pulse(EV_RET | EV_BKPT);
        chk(master_state, 1'b0);
        tick();
        pulse(8'h10);
        chk(master_state, 1'b0);
        $display("disabled causes test done");
        print_verdict();
    end
endmodule : test_thread_exception_status_control
`default_nettype wire
